/* File: core/eth_frame_regs.svh */
`ifndef ETH_FRAME_REGS_SVH
`define ETH_FRAME_REGS_SVH

// register byte offsets
`define CTRL_OFS         8'h00
`define RXSTAT_OFS       8'h04
`define INT_STAT_OFS     8'h08
`define INT_MASK_OFS     8'h0C

// control fields
`define CTRL_FCS_BIT     0
`define CTRL_PAD_BIT     1
`define CTRL_STRIP_BIT   2
`define CTRL_RST         3'h0

// interrupt status and mask fields
`define INT_RX_DONE_BIT  0
`define INT_LEN_ERR_BIT  1
`define INT_TX_DONE_BIT  2
`define INT_RST          3'h0

// transmit size and crc constants
`define TX_MIN_BYTES     6'h3C
`define CRC_INIT         32'hFFFFFFFF
`define CRC_POLY         32'hEDB88320

// receive sizes and byte positions
`define RX_MIN_FRAME     11'h040
`define RX_MIN_FIELD     16'h002E
`define RX_FIELD_HI      11'h00C
`define RX_FIELD_LO      11'h00D
`define RX_PAY_OFS       11'h00E
`define RX_PAD_END       11'h03C
`define RX_CNT_MAX       11'h7FF

`endif

/* File: core/eth_frame_pkg.sv */
package eth_frame_pkg;

  typedef enum logic [2:0]
  {
    TX_DATA = 3'h1,
    TX_PAD  = 3'h2,
    TX_FCS  = 3'h4
  } tx_state_t;

  typedef enum logic [2:0]
  {
    SEL_CTRL   = 3'h0,
    SEL_RXSTAT = 3'h1,
    SEL_ISTAT  = 3'h2,
    SEL_IMASK  = 3'h3,
    SEL_NONE   = 3'h4
  } reg_sel_t;

endpackage

/* File: core/frame_ctl_if.sv */
`timescale 1ns/1ps
interface frame_ctl_if;
  logic fcs_en;
  logic pad_en;
  logic done;
  logic fcs_added;

  modport ctl    (output fcs_en, output pad_en, input done, input fcs_added);
  modport framer (input fcs_en, input pad_en, output done, output fcs_added);
endinterface

/* File: core/tx_framer.sv */
`timescale 1ns/1ps
`include "eth_frame_regs.svh"
module tx_framer
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // frame bytes from the processing engine
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // bytes toward the line
  output logic [7:0]      line_data,
  output logic            line_valid,
  output logic            line_last,
  // controls and events
  frame_ctl_if.framer     ctl
);

  typedef struct packed
  {
    eth_frame_pkg::tx_state_t state;
    logic [5:0]               cnt;
    logic [31:0]              crc;
    logic [1:0]               fidx;
    logic                     rdy;
    logic [7:0]               data;
    logic                     vld;
    logic                     lst;
    logic                     done;
    logic                     fcs;
  } framer_st_t;

  framer_st_t st_reg;
  framer_st_t st_next;
  logic [31:0] crc_fin;
  logic        short_frame;

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign crc_fin     = ~st_reg.crc;
  // byte now taken is below the minimum payload size
  assign short_frame = st_reg.cnt < (`TX_MIN_BYTES - 6'h01);

  always_comb
  begin
    st_next      = st_reg;
    st_next.vld  = 1'b0;
    st_next.lst  = 1'b0;
    st_next.done = 1'b0;
    case (st_reg.state)
      eth_frame_pkg::TX_DATA:
        if (tx_valid && st_reg.rdy)
        begin
          st_next.data = tx_data;
          st_next.vld  = 1'b1;
          st_next.crc  = crc_byte(st_reg.crc, tx_data);
          st_next.cnt  = (st_reg.cnt == 6'h3F) ? st_reg.cnt
                                               : st_reg.cnt + 6'h01;
          if (tx_last)
          begin
            // padding outranks a cleared append control
            if (ctl.pad_en && short_frame)
              st_next.state = eth_frame_pkg::TX_PAD;
            else if (ctl.fcs_en)
            begin
              st_next.state = eth_frame_pkg::TX_FCS;
              st_next.fidx  = 2'h0;
            end
            else
            begin
              st_next.lst  = 1'b1;
              st_next.done = 1'b1;
              st_next.fcs  = 1'b0;
              st_next.cnt  = 6'h00;
              st_next.crc  = `CRC_INIT;
            end
          end
        end
      eth_frame_pkg::TX_PAD:
      begin
        st_next.data = 8'h00;
        st_next.vld  = 1'b1;
        st_next.crc  = crc_byte(st_reg.crc, 8'h00);
        st_next.cnt  = st_reg.cnt + 6'h01;
        if (st_reg.cnt == `TX_MIN_BYTES - 6'h01)
        begin
          st_next.state = eth_frame_pkg::TX_FCS;
          st_next.fidx  = 2'h0;
        end
      end
      eth_frame_pkg::TX_FCS:
      begin
        // check sequence leaves low byte first
        st_next.data = crc_fin[{st_reg.fidx, 3'h0} +: 8];
        st_next.vld  = 1'b1;
        st_next.fidx = st_reg.fidx + 2'h1;
        if (st_reg.fidx == 2'h3)
        begin
          st_next.lst   = 1'b1;
          st_next.done  = 1'b1;
          st_next.fcs   = 1'b1;
          st_next.state = eth_frame_pkg::TX_DATA;
          st_next.cnt   = 6'h00;
          st_next.crc   = `CRC_INIT;
        end
      end
      default:
        st_next.state = eth_frame_pkg::TX_DATA;
    endcase
    // ready is registered, so it drops the cycle after a last byte that pad or check sequence follows
    st_next.rdy = (st_next.state == eth_frame_pkg::TX_DATA);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg       <= '0;
      st_reg.state <= eth_frame_pkg::TX_DATA;
      st_reg.crc   <= `CRC_INIT;
      st_reg.rdy   <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign tx_ready      = st_reg.rdy;
  assign line_data     = st_reg.data;
  assign line_valid    = st_reg.vld;
  assign line_last     = st_reg.lst;
  assign ctl.done      = st_reg.done;
  assign ctl.fcs_added = st_reg.fcs;

  sequence s_short_last;
    tx_valid && tx_ready && tx_last && ctl.pad_en && short_frame;
  endsequence

  sequence s_plain_last;
    tx_valid && tx_ready && tx_last && !ctl.fcs_en &&
      !(ctl.pad_en && short_frame);
  endsequence

  a_short_gets_fcs: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_short_last |=> (st_reg.state == eth_frame_pkg::TX_PAD)
      ##[1:64] (line_last && ctl.fcs_added))
    else $error("short padded frame ended without check sequence");

  a_fcs_omitted: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_plain_last |=> line_valid && line_last && !ctl.fcs_added)
    else $error("check sequence appended while append control clear");

  a_pad_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st_reg.state == eth_frame_pkg::TX_PAD) |=>
      line_valid && line_data == 8'h00 && !line_last)
    else $error("pad byte not zero");

endmodule

/* File: core/eth_frame_ctrl.sv */
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "eth_frame_regs.svh"
module eth_frame_ctrl
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  // transmit bytes from the processing engine
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  input  wire logic        tx_last,
  output logic             tx_ready,
  // transmit bytes to the line
  output logic [7:0]       line_tx_data,
  output logic             line_tx_valid,
  output logic             line_tx_last,
  // receive bytes from the line pins
  input  wire logic [7:0]  line_rx_data,
  input  wire logic        line_rx_valid,
  input  wire logic        line_rx_last,
  // receive bytes to the processing engine
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             rx_last
);

  typedef struct packed
  {
    logic [7:0]  s1_d;
    logic        s1_v;
    logic        s1_l;
    logic [7:0]  s2_d;
    logic        s2_v;
    logic        s2_l;
    logic [10:0] rcnt;
    logic [15:0] field;
    logic [7:0]  rd;
    logic        rv;
    logic        rl;
    logic [10:0] rlen;
    logic        rerr;
    logic [15:0] rfield;
    logic [2:0]  ctrl;
    logic [2:0]  ist;
    logic [2:0]  imask;
    logic        irq;
    logic [31:0] hrdata;
    logic        wpend;
    eth_frame_pkg::reg_sel_t wsel;
    logic        hrdy;
  } top_st_t;

  top_st_t     st_reg;
  top_st_t     st_next;
  frame_ctl_if ctl_bus ();
  logic        addr_ok;
  logic [10:0] rx_total;
  logic        field_short;
  logic        rx_end;
  logic        len_bad;
  logic        drop_pad;

  function automatic eth_frame_pkg::reg_sel_t decode(input logic [31:0] a);
    case (a)
      {24'h000000, `CTRL_OFS}:     decode = eth_frame_pkg::SEL_CTRL;
      {24'h000000, `RXSTAT_OFS}:   decode = eth_frame_pkg::SEL_RXSTAT;
      {24'h000000, `INT_STAT_OFS}: decode = eth_frame_pkg::SEL_ISTAT;
      {24'h000000, `INT_MASK_OFS}: decode = eth_frame_pkg::SEL_IMASK;
      default:                     decode = eth_frame_pkg::SEL_NONE;
    endcase
  endfunction

  assign addr_ok     = hsel && hready && htrans[1];
  assign rx_total    = (st_reg.rcnt == `RX_CNT_MAX) ? st_reg.rcnt
                                                   : st_reg.rcnt + 11'h001;
  assign field_short = (st_reg.field != 16'h0000) &&
                       (st_reg.field < `RX_MIN_FIELD);
  assign rx_end      = st_reg.s2_v && st_reg.s2_l;
  // error only judged with pad removal on
  assign len_bad     = st_reg.ctrl[`CTRL_STRIP_BIT] &&
                       (rx_total != `RX_MIN_FRAME) && field_short;
  // pad lies between the declared payload and the 60 byte mark
  assign drop_pad    = st_reg.ctrl[`CTRL_STRIP_BIT] && field_short &&
                       (st_reg.rcnt >= st_reg.field[10:0] + `RX_PAY_OFS) &&
                       (st_reg.rcnt < `RX_PAD_END) && !st_reg.s2_l;

  assign ctl_bus.fcs_en = st_reg.ctrl[`CTRL_FCS_BIT];
  assign ctl_bus.pad_en = st_reg.ctrl[`CTRL_PAD_BIT];

  always_comb
  begin
    logic [2:0] set_bits;
    logic [2:0] clr_bits;
    set_bits = 3'h0;
    clr_bits = 3'h0;
    st_next  = st_reg;

    // two flops on the line pins, the first read by nothing else
    st_next.s1_d = line_rx_data;
    st_next.s1_v = line_rx_valid;
    st_next.s1_l = line_rx_last;
    st_next.s2_d = st_reg.s1_d;
    st_next.s2_v = st_reg.s1_v;
    st_next.s2_l = st_reg.s1_l;

    st_next.rv = 1'b0;
    st_next.rl = 1'b0;
    if (st_reg.s2_v)
    begin
      st_next.rcnt = rx_total;
      if (st_reg.rcnt == `RX_FIELD_HI)
        st_next.field[15:8] = st_reg.s2_d;
      if (st_reg.rcnt == `RX_FIELD_LO)
        st_next.field[7:0] = st_reg.s2_d;
      st_next.rd = st_reg.s2_d;
      st_next.rv = !drop_pad;
      st_next.rl = st_reg.s2_l;
      if (st_reg.s2_l)
      begin
        st_next.rlen   = rx_total;
        st_next.rerr   = len_bad;
        st_next.rfield = st_reg.field;
        st_next.rcnt   = 11'h000;
        st_next.field  = 16'h0000;
        set_bits[`INT_RX_DONE_BIT] = 1'b1;
        set_bits[`INT_LEN_ERR_BIT] = len_bad;
      end
    end
    set_bits[`INT_TX_DONE_BIT] = ctl_bus.done;

    // address phase: read data prepared now, shown in the data phase
    st_next.hrdy  = 1'b1;
    st_next.wpend = addr_ok && hwrite;
    st_next.wsel  = decode(haddr);
    if (addr_ok && !hwrite)
      case (decode(haddr))
        eth_frame_pkg::SEL_CTRL:   st_next.hrdata = {29'h0, st_reg.ctrl};
        eth_frame_pkg::SEL_RXSTAT: st_next.hrdata = {st_reg.rfield, 4'h0,
                                                    st_reg.rerr,
                                                    st_reg.rlen};
        eth_frame_pkg::SEL_ISTAT:  st_next.hrdata = {29'h0, st_reg.ist};
        eth_frame_pkg::SEL_IMASK:  st_next.hrdata = {29'h0, st_reg.imask};
        default:                   st_next.hrdata = 32'h00000000;
      endcase

    // data phase of a write
    if (st_reg.wpend)
      case (st_reg.wsel)
        eth_frame_pkg::SEL_CTRL:  st_next.ctrl  = hwdata[2:0];
        eth_frame_pkg::SEL_ISTAT: clr_bits      = hwdata[2:0];
        eth_frame_pkg::SEL_IMASK: st_next.imask = hwdata[2:0];
        default:                  clr_bits      = 3'h0;
      endcase

    // a new event beats a clear in the same cycle
    st_next.ist = (st_reg.ist & ~clr_bits) | set_bits;
    st_next.irq = |(st_next.ist & st_next.imask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg       <= '0;
      st_reg.ctrl  <= `CTRL_RST;
      st_reg.ist   <= `INT_RST;
      st_reg.imask <= `INT_RST;
      st_reg.wsel  <= eth_frame_pkg::SEL_NONE;
      st_reg.hrdy  <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  tx_framer u_framer
  (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .tx_data    (tx_data),
    .tx_valid   (tx_valid),
    .tx_last    (tx_last),
    .tx_ready   (tx_ready),
    .line_data  (line_tx_data),
    .line_valid (line_tx_valid),
    .line_last  (line_tx_last),
    .ctl        (ctl_bus.framer)
  );

  assign hrdata    = st_reg.hrdata;
  assign hreadyout = st_reg.hrdy;
  assign hresp     = 1'b0 & st_reg.hrdy;
  assign irq       = st_reg.irq;
  assign rx_data   = st_reg.rd;
  assign rx_valid  = st_reg.rv;
  assign rx_last   = st_reg.rl;

  sequence s_rx_end_bad;
    rx_end && st_reg.ctrl[`CTRL_STRIP_BIT] && field_short &&
      (rx_total != `RX_MIN_FRAME);
  endsequence

  a_no_err_unstripped: assert property (
    @(posedge ref_clk) disable iff (rst)
    rx_end && !st_reg.ctrl[`CTRL_STRIP_BIT] |=> !st_reg.rerr)
    else $error("length error raised with pad removal off");

  a_err_raised: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_rx_end_bad |=> st_reg.rerr && st_reg.ist[`INT_LEN_ERR_BIT])
    else $error("length error not raised");

  a_err_exact: assert property (
    @(posedge ref_clk) disable iff (rst)
    rx_end && rx_total == `RX_MIN_FRAME |=> !st_reg.rerr)
    else $error("length error on a 64 byte frame");

  // every status read, not only one right after a bad frame
  a_status_read: assert property (
    @(posedge ref_clk) disable iff (rst)
    addr_ok && !hwrite && haddr == {24'h000000, `RXSTAT_OFS} |=>
      hrdata[11] == $past(st_reg.rerr))
    else $error("status read misses length error");

  a_irq_level: assert property (
    @(posedge ref_clk) disable iff (rst)
    ##1 irq == |($past(st_next.ist) & $past(st_next.imask)))
    else $error("interrupt level wrong");

endmodule

/* File: verification/line_model.sv */
`timescale 1ns/1ps
module line_model
(
  // clock
  input  wire logic       ref_clk,
  // bytes sent by the block
  input  wire logic [7:0] line_tx_data,
  input  wire logic       line_tx_valid,
  input  wire logic       line_tx_last,
  // bytes into the block
  output logic [7:0]      line_rx_data,
  output logic            line_rx_valid,
  output logic            line_rx_last
);
  logic [7:0] got[$];
  logic [8:0] q[$];
  int         ends;

  initial
  begin
    line_rx_data  = 8'h00;
    line_rx_valid = 1'b0;
    line_rx_last  = 1'b0;
    ends          = 0;
  end

  always @(posedge ref_clk)
  begin
    if (line_tx_valid === 1'b1)
      got.push_back(line_tx_data);
    if (line_tx_valid === 1'b1 && line_tx_last === 1'b1)
      ends = ends + 1;
    if (q.size() != 0)
    begin
      {line_rx_last, line_rx_data} <= q.pop_front();
      line_rx_valid                <= 1'b1;
    end
    else
    begin
      // idle line inverts the data every cycle, with valid and last held low
      line_rx_data  <= ~line_rx_data;
      line_rx_valid <= 1'b0;
      line_rx_last  <= 1'b0;
    end
  end

  // length field sits at bytes 12 and 13, high byte first
  task automatic send_frame(input int len, input logic [15:0] field);
    for (int i = 0; i < len; i++)
      q.push_back({i == len - 1, i == 12 ? field[15:8] :
                   i == 13 ? field[7:0] : 8'(i)});
    while (q.size() != 0)
      @(posedge ref_clk);
  endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`include "eth_frame_regs.svh"
module tb_top;
  localparam logic [31:0] A_CTRL = {24'h00, `CTRL_OFS};
  localparam logic [31:0] A_RXST = {24'h00, `RXSTAT_OFS};
  localparam logic [31:0] A_IST  = {24'h00, `INT_STAT_OFS};
  localparam logic [31:0] A_IMSK = {24'h00, `INT_MASK_OFS};

  logic        ref_clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        irq;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_last;
  logic        tx_ready;
  logic [7:0]  line_tx_data;
  logic        line_tx_valid;
  logic        line_tx_last;
  logic [7:0]  line_rx_data;
  logic        line_rx_valid;
  logic        line_rx_last;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_last;
  logic [7:0]  rx_tail;
  logic        hresp;
  int          rx_seen;
  int          rx_ends;
  int          err_total;
  int          compares;
  int          cycles;

  eth_frame_ctrl uut
  (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (3'h2),
    .hwdata        (hwdata),
    .hready        (hreadyout),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .irq           (irq),
    .tx_data       (tx_data),
    .tx_valid      (tx_valid),
    .tx_last       (tx_last),
    .tx_ready      (tx_ready),
    .line_tx_data  (line_tx_data),
    .line_tx_valid (line_tx_valid),
    .line_tx_last  (line_tx_last),
    .line_rx_data  (line_rx_data),
    .line_rx_valid (line_rx_valid),
    .line_rx_last  (line_rx_last),
    .rx_data       (rx_data),
    .rx_valid      (rx_valid),
    .rx_last       (rx_last)
  );

  line_model lm
  (
    .ref_clk       (ref_clk),
    .line_tx_data  (line_tx_data),
    .line_tx_valid (line_tx_valid),
    .line_tx_last  (line_tx_last),
    .line_rx_data  (line_rx_data),
    .line_rx_valid (line_rx_valid),
    .line_rx_last  (line_rx_last)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task close_out;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ceiling well above the roughly one thousand cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      close_out();
    end
  end

  // receive stream as the engine would see it
  always @(posedge ref_clk)
  begin
    if (rx_valid === 1'b1)
    begin
      rx_seen = rx_seen + 1;
      if (rx_last === 1'b1)
      begin
        rx_ends = rx_ends + 1;
        rx_tail = rx_data;
      end
    end
  end

  // plain crc-32 over the first m bytes seen on the line
  function automatic logic [31:0] fcs_of(input int m);
    logic [31:0] r;
    r = 32'hFFFFFFFF;
    for (int i = 0; i < m; i++)
    begin
      r = r ^ {24'h000000, lm.got[i]};
      for (int b = 0; b < 8; b++)
        r = r[0] ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
    end
    return ~r;
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares = compares + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask

  task bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
           output logic [31:0] rd);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task t_regs;
    logic [31:0] d;
    bus(A_CTRL, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    bus(A_RXST, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    bus(A_IST, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    bus(A_IMSK, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    bus(32'h10, 1'b1, 32'hFFFFFFFF, d);
    chk({31'h0, hresp}, 32'h0);
    bus(32'h10, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    bus(A_CTRL, 1'b1, 32'h7, d);
    bus(A_CTRL, 1'b0, 32'h0, d);
    chk(d, 32'h7);
    $display("test regs done");
  endtask

  task tx_case(input logic [31:0] c, input int n, input int e);
    logic [31:0] d;
    int          k;
    bus(A_CTRL, 1'b1, c, d);
    lm.got.delete();
    k = lm.ends;
    for (int i = 0; i < n; i++)
    begin
      tx_data  <= 8'(i + 1);
      tx_valid <= 1'b1;
      tx_last  <= (i == n - 1);
      do @(posedge ref_clk); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
    tx_last  <= 1'b0;
    while (lm.ends == k)
      @(posedge ref_clk);
    chk(32'(lm.got.size()), 32'(e));
    for (int i = 0; i < n && i < e; i++)
      chk({24'h0, lm.got[i]}, 32'(i + 1));
    for (int i = n; i < 60 && c[1]; i++)
      chk({24'h0, lm.got[i]}, 32'h0);
    if (e != n)
      chk({lm.got[e-1], lm.got[e-2], lm.got[e-3], lm.got[e-4]},
          fcs_of(e - 4));
    repeat (2) @(posedge ref_clk);
    bus(A_IST, 1'b0, 32'h0, d);
    chk(d & 32'h4, 32'h4);
    bus(A_IST, 1'b1, 32'h7, d);
  endtask

  task t_tx;
    tx_case(32'h0, 10, 10);
    tx_case(32'h1, 10, 14);
    tx_case(32'h2, 10, 64);
    tx_case(32'h3, 59, 64);
    tx_case(32'h2, 60, 60);
    tx_case(32'h3, 60, 64);
    $display("test tx done");
  endtask

  task rx_case(input logic s, input int len, input logic [15:0] f,
               input logic e);
    logic [31:0] d;
    int          top;
    int          keep;
    top  = (len - 1 < 60) ? len - 1 : 60;
    keep = len;
    // pad lies past the declared payload, up to the 60 byte mark
    if (s && f != 16'h0000 && f < 16'h002E && top > 14 + int'(f))
      keep = len - (top - 14 - int'(f));
    bus(A_CTRL, 1'b1, {29'h0, s, 2'h0}, d);
    bus(A_IMSK, 1'b1, 32'h2, d);
    rx_seen = 0;
    rx_ends = 0;
    lm.send_frame(len, f);
    repeat (6) @(posedge ref_clk);
    chk(32'(rx_seen), 32'(keep));
    chk(32'(rx_ends), 32'h1);
    chk({24'h0, rx_tail}, {24'h0, 8'(len - 1)});
    bus(A_RXST, 1'b0, 32'h0, d);
    chk(d, {f, 4'h0, e, 11'(len)});
    chk({31'h0, irq}, {31'h0, e});
    bus(A_IST, 1'b0, 32'h0, d);
    chk(d & 32'h3, {30'h0, e, 1'b1});
    bus(A_IST, 1'b1, 32'h7, d);
    bus(A_IST, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task t_rx;
    rx_case(1'b0, 60, 16'h000A, 1'b0);
    rx_case(1'b0, 70, 16'h0001, 1'b0);
    rx_case(1'b1, 60, 16'h000A, 1'b1);
    rx_case(1'b1, 64, 16'h000A, 1'b0);
    rx_case(1'b1, 60, 16'h0000, 1'b0);
    rx_case(1'b1, 60, 16'h002E, 1'b0);
    rx_case(1'b1, 60, 16'h002D, 1'b1);
    rx_case(1'b1, 70, 16'h0001, 1'b1);
    $display("test rx done");
  endtask

  initial
  begin
    err_total = 0;
    compares  = 0;
    cycles    = 0;
    rst       = 1'b1;
    hsel      = 1'b1;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hwdata    = 32'h0;
    tx_data   = 8'h00;
    tx_valid  = 1'b0;
    tx_last   = 1'b0;
    rx_seen   = 0;
    rx_ends   = 0;
    rx_tail   = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_tx();
    t_rx();
    close_out();
  end
endmodule
